// file: hw/egress_qos_marker_scheduler.v
// egress qos stage: strict-priority plus wfq scheduler, queue statistics,
// outer vlan marker and global ethertype / frame size settings
// assumes inputs synchronous to CLK and an apb master for configuration
//
// What this block does
// [R1] queue priority levels 1 to 4, 4 highest
// [R2] cos 7 always served as highest priority
// [R3] nine priority profiles, ninth fixed read-only
// [R4] one attached profile, profile 9 after reset
// [R5] equal-priority queues share by weight ratio
// [R6] six wfq profiles, first fixed and default
// [R7] 64-bit tx/drop packet and byte counters
// [R8] 32-bit green and yellow bit-rate per queue
// [R9] rewrite only when outer tag preservation off
// [R10] preservation keeps ingress cos and colour
// [R11] global table: cos+colour to pcp, colour to dei
// [R12] marking enabled overwrites from the global table
// [R13] marking and preservation off: green entries used
// [R14] preservation on: added tag carries zeros
// [R15] separate c and s table, reset pcp equals cos
// [R16] default dei: green 0, yellow 1
// [R17] selectable s-vlan ethertype, reset 0x88A8
// [R18] c-vlan ethertype is 0x8100 only
// [R19] global max frame size 64 to 9612
// [R20] eight queues per port, one per cos
// [R21] higher level always served before lower
// [R22] oversize frames flagged for discard
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "egress_qos_consts.vh"
module egress_qos_marker_scheduler
#(
	parameter RATE_WIN_CYC = `RATE_WIN_CYC // cycles per rate window
)
(
	input wire CLK,
	input wire RST_B,
	// apb slave
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output wire [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	// scheduler
	input wire [7:0] QUEUE_READY,
	input wire GRANT_TAKE,
	output wire GRANT_VALID,
	output wire [2:0] GRANT_QUEUE,
	// statistics events
	input wire TX_DONE,
	input wire [2:0] TX_QUEUE,
	input wire TX_YELLOW,
	input wire [13:0] TX_BYTES,
	input wire DROP_EV,
	input wire [2:0] DROP_QUEUE,
	input wire DROP_YELLOW,
	input wire [13:0] DROP_BYTES,
	// marker frame in
	input wire FRM_VALID,
	input wire [15:0] FRM_ETYPE,
	input wire [2:0] FRM_COS,
	input wire FRM_YELLOW,
	input wire FRM_MARK_EN,
	input wire FRM_ADD_TAG,
	input wire [13:0] FRM_LEN,
	// marker result
	output wire OUT_VALID,
	output wire [2:0] OUT_PCP,
	output wire OUT_DEI,
	output wire OUT_IS_STAG,
	output wire OUT_IS_CTAG,
	output wire OUT_DROP
);
	// -----------------------------------------------------------
	// configuration state
	// -----------------------------------------------------------
	reg [3:0] pprof_r; // attached priority profile 1..9
	reg [2:0] wprof_r; // attached wfq profile 1..6
	reg spres_r; // s-vlan preservation
	reg cpres_r; // c-vlan preservation
	reg [1:0] sety_r; // s-vlan ethertype select
	reg [13:0] mru_r; // max frame size in bytes
	reg [31:0] prio_prof [0:7]; // user priority profiles 1..8
	reg [31:0] wfq_prof [0:4]; // user wfq profiles 2..6
	reg [11:0] mark_tab [0:7]; // per cos: c grn,c yel,s grn,s yel
	reg [1:0] dei_r; // dei per colour
	reg [5:0] cnt_sel_r; // counter / rate select
	reg [31:0] hi_latch_r; // upper word caught on low read
	integer i;

	// -----------------------------------------------------------
	// helpers
	// -----------------------------------------------------------
	// level of queue q in a profile word; cos 7 outranks every level
	function [2:0] q_level;
		input [31:0] prof;
		input [2:0] q;
		begin
			if (q == 3'h7)
				q_level = 3'h5; // R2
			else
				q_level = prof[q*4 +: 3]; // R1
		end
	endfunction

	// clamp a 4-bit field into 1..4 so levels stay legal
	function [3:0] clamp_prio;
		input [3:0] v;
		begin
			if (v == 4'h0)
				clamp_prio = 4'h1;
			else if (v > 4'h4)
				clamp_prio = 4'h4;
			else
				clamp_prio = v;
		end
	endfunction

	// -----------------------------------------------------------
	// active profile words
	// -----------------------------------------------------------
	wire [31:0] act_prio; // priority word in use
	wire [31:0] act_wfq; // weight word in use
	assign act_prio = (pprof_r == `NUM_PPROF) ? `DEF_PRIO :
		prio_prof[pprof_r[2:0] - 3'h1]; // R3 R4
	assign act_wfq = (wprof_r == 3'h1) ? `DEF_WFQ :
		wfq_prof[wprof_r - 3'h2]; // R6

	// -----------------------------------------------------------
	// scheduler selection (eight queues, one per cos)
	// -----------------------------------------------------------
	reg [3:0] credit_r [0:7]; // wfq frames left this round
	reg grant_v_r; // offer pending
	reg [2:0] grant_q_r; // offered queue
	reg [2:0] top_lvl; // highest level among ready
	reg [7:0] elig; // ready at top level
	reg [7:0] with_cred; // eligible with credit left
	reg [2:0] pick; // chosen queue
	reg reload; // start a new wfq round
	reg [3:0] wgt; // scratch weight
	always @*
	begin
		top_lvl = 3'h0;
		elig = 8'h00;
		with_cred = 8'h00;
		pick = 3'h0;
		reload = 1'b0;
		wgt = 4'h0;
		for (i = 0; i < 8; i = i + 1) // R20
			if (QUEUE_READY[i] && q_level(act_prio, i[2:0]) > top_lvl)
				top_lvl = q_level(act_prio, i[2:0]); // R21
		for (i = 0; i < 8; i = i + 1)
		begin
			elig[i] = QUEUE_READY[i] &&
				q_level(act_prio, i[2:0]) == top_lvl; // R21
			with_cred[i] = elig[i] && credit_r[i] != 4'h0; // R5
		end
		// lowest index wins inside a round; ratio set by weights
		reload = (with_cred == 8'h00);
		for (i = 7; i >= 0; i = i - 1)
			if (reload ? elig[i] : with_cred[i])
				pick = i[2:0];
	end

	// offer held until the port takes it; no change mid-offer
	always @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			grant_v_r <= 1'b0;
			grant_q_r <= 3'h0;
			for (i = 0; i < 8; i = i + 1)
				credit_r[i] <= 4'h0;
		end
		else if (grant_v_r)
		begin
			if (GRANT_TAKE)
				grant_v_r <= 1'b0;
		end
		else if (QUEUE_READY != 8'h00)
		begin
			grant_v_r <= 1'b1;
			grant_q_r <= pick;
			if (reload)
			begin
				// refill eligible queues; weight 0 acts as 1
				// the picked queue spends one now, so the others get a turn
				for (i = 0; i < 8; i = i + 1)
					if (elig[i])
						credit_r[i] <= ((act_wfq[i*4 +: 4] == 4'h0) ?
							4'h1 : act_wfq[i*4 +: 4]) -
							{3'h0, pick == i[2:0]}; // R5
			end
			else
				credit_r[pick] <= credit_r[pick] - 4'h1; // R5
		end
	end
	assign GRANT_VALID = grant_v_r;
	assign GRANT_QUEUE = grant_q_r;

	// -----------------------------------------------------------
	// queue statistics
	// -----------------------------------------------------------
	// index: [4] drop, [3] yellow, [2:0] queue
	reg [63:0] pkt_cnt [0:31]; // packet counters
	reg [63:0] byt_cnt [0:31]; // byte counters
	reg [31:0] rate_acc [0:15]; // bytes in current window
	reg [31:0] rate_r [0:15]; // bits per second, last window
	reg [25:0] win_cnt_r; // rate window timer
	wire [4:0] tx_idx; // tx counter index
	wire [4:0] dr_idx; // drop counter index
	wire [3:0] rt_idx; // rate index
	wire win_end; // last cycle of window
	assign tx_idx = {1'b0, TX_YELLOW, TX_QUEUE};
	assign dr_idx = {1'b1, DROP_YELLOW, DROP_QUEUE};
	assign rt_idx = {TX_YELLOW, TX_QUEUE};
	assign win_end = (win_cnt_r == RATE_WIN_CYC[25:0] - 26'h1);

	// tx and drop live in separate halves so both may land at once
	always @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			for (i = 0; i < 32; i = i + 1)
			begin
				pkt_cnt[i] <= 64'h0;
				byt_cnt[i] <= 64'h0;
			end
		end
		else
		begin
			if (TX_DONE)
			begin
				pkt_cnt[tx_idx] <= pkt_cnt[tx_idx] + 64'h1; // R7
				byt_cnt[tx_idx] <= byt_cnt[tx_idx] + {50'h0, TX_BYTES}; // R7
			end
			if (DROP_EV)
			begin
				pkt_cnt[dr_idx] <= pkt_cnt[dr_idx] + 64'h1; // R7
				byt_cnt[dr_idx] <= byt_cnt[dr_idx] +
					{50'h0, DROP_BYTES}; // R7
			end
		end
	end

	// one-second window; rate is bytes times eight, latched at end
	always @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			win_cnt_r <= 26'h0;
			for (i = 0; i < 16; i = i + 1)
			begin
				rate_acc[i] <= 32'h0;
				rate_r[i] <= 32'h0;
			end
		end
		else
		begin
			win_cnt_r <= win_end ? 26'h0 : win_cnt_r + 26'h1;
			for (i = 0; i < 16; i = i + 1)
			begin
				if (win_end)
				begin
					// a frame ending on the last cycle counts in
					rate_r[i] <= {rate_acc[i][28:0], 3'h0} +
						((TX_DONE && rt_idx == i[3:0]) ?
						{15'h0, TX_BYTES, 3'h0} : 32'h0); // R8
					rate_acc[i] <= 32'h0;
				end
				else if (TX_DONE && rt_idx == i[3:0])
					rate_acc[i] <= rate_acc[i] + {18'h0, TX_BYTES}; // R8
			end
		end
	end

	// -----------------------------------------------------------
	// marker
	// -----------------------------------------------------------
	reg [15:0] s_ety; // selected s-vlan ethertype
	reg is_s; // outer tag is s-vlan
	reg is_c; // outer tag is c-vlan
	reg keep; // preservation applies
	reg [2:0] pcp_nxt; // next pcp
	reg dei_nxt; // next dei
	reg [11:0] ent; // table entry for this cos
	always @*
	begin
		case (sety_r) // R17
			2'h0: s_ety = `ETY_8100;
			2'h1: s_ety = `ETY_88A8;
			2'h2: s_ety = `ETY_9100;
			default: s_ety = `ETY_9200;
		endcase
		// s wins when 0x8100 is also chosen as the s type
		is_s = (FRM_ETYPE == s_ety); // R17
		is_c = !is_s && FRM_ETYPE == `ETY_8100; // R18
		keep = (is_s && spres_r) || (is_c && cpres_r); // R9
		ent = mark_tab[FRM_COS]; // R11
		pcp_nxt = FRM_COS;
		dei_nxt = FRM_YELLOW;
		if (keep)
		begin
			if (FRM_ADD_TAG)
			begin
				pcp_nxt = 3'h0; // R14
				dei_nxt = 1'b0; // R14
			end
			else
			begin
				pcp_nxt = FRM_COS; // R10
				dei_nxt = FRM_YELLOW; // R10
			end
		end
		else if (FRM_MARK_EN)
		begin
			// colour picks the entry half, tag type the table
			if (is_s || FRM_ADD_TAG)
				pcp_nxt = FRM_YELLOW ? ent[11:9] : ent[8:6]; // R12
			else
				pcp_nxt = FRM_YELLOW ? ent[5:3] : ent[2:0]; // R12
			dei_nxt = dei_r[FRM_YELLOW]; // R11
		end
		else
		begin
			pcp_nxt = (is_s || FRM_ADD_TAG) ? ent[8:6] : ent[2:0]; // R13
			dei_nxt = dei_r[0]; // R13
		end
	end

	reg out_v_r; // result valid
	reg [2:0] out_pcp_r; // result pcp
	reg out_dei_r; // result dei
	reg out_s_r; // outer s-tag seen
	reg out_c_r; // outer c-tag seen
	reg out_drop_r; // oversize, discard
	// one cycle behind the frame input
	always @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			out_v_r <= 1'b0;
			out_pcp_r <= 3'h0;
			out_dei_r <= 1'b0;
			out_s_r <= 1'b0;
			out_c_r <= 1'b0;
			out_drop_r <= 1'b0;
		end
		else
		begin
			out_v_r <= FRM_VALID;
			if (FRM_VALID)
			begin
				out_pcp_r <= pcp_nxt;
				out_dei_r <= dei_nxt;
				out_s_r <= is_s;
				out_c_r <= is_c;
				out_drop_r <= FRM_LEN > mru_r; // R22 R19
			end
		end
	end
	assign OUT_VALID = out_v_r;
	assign OUT_PCP = out_pcp_r;
	assign OUT_DEI = out_dei_r;
	assign OUT_IS_STAG = out_s_r;
	assign OUT_IS_CTAG = out_c_r;
	assign OUT_DROP = out_drop_r;

	// -----------------------------------------------------------
	// apb slave, zero wait states
	// -----------------------------------------------------------
	wire wr; // write access phase
	wire rd; // read access phase
	reg [31:0] rdata; // decoded read data
	reg hit; // address mapped
	reg wr_ok; // address writable
	wire [5:0] sel_cnt; // counter index incl. bytes bit
	assign wr = PSEL && PENABLE && PWRITE;
	assign rd = PSEL && PENABLE && !PWRITE;
	assign sel_cnt = cnt_sel_r;
	always @*
	begin
		rdata = 32'h0;
		hit = 1'b1;
		wr_ok = 1'b1;
		if (PADDR >= `A_PRIO_BASE && PADDR < `A_PRIO_DEF &&
			PADDR[1:0] == 2'h0)
			rdata = prio_prof[PADDR[4:2]];
		else if (PADDR >= `A_WFQ_BASE && PADDR < `A_WFQ_BASE + 8'h18 &&
			PADDR[1:0] == 2'h0)
		begin
			rdata = (PADDR == `A_WFQ_BASE) ? `DEF_WFQ :
				wfq_prof[PADDR[4:2] - 3'h1];
			wr_ok = (PADDR != `A_WFQ_BASE); // R6
		end
		else if (PADDR >= `A_MARK_BASE && PADDR < `A_DEI_MAP &&
			PADDR[1:0] == 2'h0)
			rdata = {20'h0, mark_tab[PADDR[4:2]]};
		else
			case (PADDR)
				`A_CTRL: rdata = {20'h0, sety_r, cpres_r, spres_r,
					1'b0, wprof_r, pprof_r};
				`A_MRU: rdata = {18'h0, mru_r};
				`A_STATUS:
				begin
					rdata = {24'h0, grant_v_r, grant_q_r, 4'h0};
					wr_ok = 1'b0;
				end
				`A_PRIO_DEF:
				begin
					rdata = `DEF_PRIO; // R3
					wr_ok = 1'b0;
				end
				`A_DEI_MAP: rdata = {30'h0, dei_r};
				`A_CNT_SEL: rdata = {26'h0, cnt_sel_r};
				`A_CNT_LO:
				begin
					rdata = sel_cnt[5] ? byt_cnt[sel_cnt[4:0]][31:0] :
						pkt_cnt[sel_cnt[4:0]][31:0];
					wr_ok = 1'b0;
				end
				`A_CNT_HI:
				begin
					rdata = hi_latch_r;
					wr_ok = 1'b0;
				end
				`A_RATE:
				begin
					rdata = rate_r[sel_cnt[3:0]];
					wr_ok = 1'b0;
				end
				default:
				begin
					hit = 1'b0;
					wr_ok = 1'b0;
				end
			endcase
	end
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && (!hit || (PWRITE && !wr_ok));
	assign PRDATA = (rd && hit) ? rdata : 32'h0;

	// register writes; bad profile numbers are ignored
	always @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			pprof_r <= `RST_PPROF; // R4
			wprof_r <= `RST_WPROF; // R6
			spres_r <= 1'b0;
			cpres_r <= 1'b0;
			sety_r <= `RST_SETY; // R17
			mru_r <= `RST_MRU;
			dei_r <= `RST_DEI; // R16
			cnt_sel_r <= 6'h0;
			hi_latch_r <= 32'h0;
			for (i = 0; i < 8; i = i + 1)
			begin
				prio_prof[i] <= `DEF_PRIO;
				mark_tab[i] <= {4{i[2:0]}}; // R15
			end
			for (i = 0; i < 5; i = i + 1)
				wfq_prof[i] <= `DEF_WFQ;
		end
		else
		begin
			// high word caught so a lo-then-hi read is coherent
			if (rd && PADDR == `A_CNT_LO)
				hi_latch_r <= sel_cnt[5] ? byt_cnt[sel_cnt[4:0]][63:32] :
					pkt_cnt[sel_cnt[4:0]][63:32];
			if (wr && wr_ok && hit)
			begin
				if (PADDR >= `A_PRIO_BASE && PADDR < `A_PRIO_DEF)
					for (i = 0; i < 8; i = i + 1)
						prio_prof[PADDR[4:2]][i*4 +: 4] <=
							clamp_prio(PWDATA[i*4 +: 4]); // R1 R3
				else if (PADDR >= `A_WFQ_BASE && PADDR < `A_MARK_BASE)
					wfq_prof[PADDR[4:2] - 3'h1] <= PWDATA; // R6
				else if (PADDR >= `A_MARK_BASE && PADDR < `A_DEI_MAP)
					mark_tab[PADDR[4:2]] <= PWDATA[11:0]; // R15
				else
					case (PADDR)
						`A_CTRL:
						begin
							if (PWDATA[3:0] != 4'h0 && PWDATA[3:0] <= `NUM_PPROF)
								pprof_r <= PWDATA[3:0]; // R4
							if (PWDATA[6:4] != 3'h0 && PWDATA[6:4] <= `NUM_WPROF)
								wprof_r <= PWDATA[6:4]; // R6
							spres_r <= PWDATA[`F_SPRES];
							cpres_r <= PWDATA[`F_CPRES];
							sety_r <= PWDATA[`F_SETY_LO +: 2]; // R17
						end
						`A_MRU:
							// out-of-range sizes are clamped
							mru_r <= (PWDATA[13:0] < `MRU_MIN ||
								PWDATA[31:14] != 18'h0) ?
								(PWDATA[31:14] != 18'h0 ? `MRU_MAX : `MRU_MIN) :
								(PWDATA[13:0] > `MRU_MAX ? `MRU_MAX :
								PWDATA[13:0]); // R19
						`A_DEI_MAP: dei_r <= PWDATA[1:0]; // R16
						`A_CNT_SEL: cnt_sel_r <= PWDATA[5:0];
						default: cnt_sel_r <= cnt_sel_r;
					endcase
			end
		end
	end
endmodule // egress_qos_marker_scheduler

// file: hw/egress_qos_consts.vh
// constants for the egress qos marker and scheduler
// assumes a 40 MHz clock and a 32-bit apb register bus
`ifndef EGRESS_QOS_CONSTS_VH
`define EGRESS_QOS_CONSTS_VH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define A_CTRL 8'h00
`define A_MRU 8'h04
`define A_STATUS 8'h08
`define A_PRIO_BASE 8'h40
`define A_PRIO_DEF 8'h60
`define A_WFQ_BASE 8'h80
`define A_MARK_BASE 8'hA0
`define A_DEI_MAP 8'hC0
`define A_CNT_SEL 8'hC4
`define A_CNT_LO 8'hC8
`define A_CNT_HI 8'hCC
`define A_RATE 8'hD0
// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define F_PPROF_LO 0
`define F_WPROF_LO 4
`define F_SPRES 8
`define F_CPRES 9
`define F_SETY_LO 10
// ---------------------------------------------------------------
// reset values and fixed tables
// ---------------------------------------------------------------
`define RST_PPROF 4'h9
`define RST_WPROF 3'h1
`define RST_SETY 2'h1
`define RST_MRU 14'h258C
`define MRU_MIN 14'h0040
`define MRU_MAX 14'h258C
`define DEF_PRIO 32'h43322221
`define DEF_WFQ 32'h11111111
`define RST_DEI 2'h2
`define NUM_PPROF 4'h9
`define NUM_WPROF 3'h6
// ---------------------------------------------------------------
// ethertypes
// ---------------------------------------------------------------
`define ETY_8100 16'h8100
`define ETY_88A8 16'h88A8
`define ETY_9100 16'h9100
`define ETY_9200 16'h9200
// ---------------------------------------------------------------
// rate window
// ---------------------------------------------------------------
`define RATE_WIN_US 1000000
`define CLK_MHZ 40
`define RATE_WIN_CYC (`RATE_WIN_US * `CLK_MHZ)
`endif

// file: verif/egress_qos_monitor.sv
// checker: port relations of the egress qos marker and scheduler
// assumes it is bound into the block and sees only its top ports
`timescale 1ns/10ps
`include "egress_qos_consts.vh"
module egress_qos_monitor
(
	input wire CLK,
	input wire RST_B,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire PSLVERR,
	input wire [7:0] QUEUE_READY,
	input wire GRANT_TAKE,
	input wire GRANT_VALID,
	input wire [2:0] GRANT_QUEUE,
	input wire FRM_VALID,
	input wire [15:0] FRM_ETYPE,
	input wire [13:0] FRM_LEN,
	input wire OUT_VALID,
	input wire OUT_IS_STAG,
	input wire OUT_IS_CTAG,
	input wire OUT_DROP
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	logic [7:0] rdy_d; // ready mask seen at the offer edge
	always @(posedge CLK)
		rdy_d <= QUEUE_READY;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// ---------------------------------------------------------------
	// marker
	// ---------------------------------------------------------------
	AST_OUT_PULSE: assert property (1'b1 |=> OUT_VALID == $past(FRM_VALID))
		else $error("marker result not one cycle after header");
	AST_DROP_BIG: assert property (FRM_VALID && FRM_LEN > 14'h258C |=> OUT_DROP)
		else $error("oversize frame not flagged");
	AST_DROP_SMALL: assert property (FRM_VALID && FRM_LEN <= 14'h0040 |=> !OUT_DROP)
		else $error("short frame flagged as oversize");
	AST_ETY_OTHER: assert property (FRM_VALID && !(FRM_ETYPE inside {16'h8100, 16'h88A8, 16'h9100, 16'h9200}) |=> !OUT_IS_STAG && !OUT_IS_CTAG)
		else $error("unknown ethertype taken as a tag");
	AST_ETY_C: assert property (FRM_VALID && FRM_ETYPE == 16'h8100 |=> OUT_IS_STAG != OUT_IS_CTAG)
		else $error("c tag ethertype not recognised");
	// ---------------------------------------------------------------
	// scheduler and register bus
	// ---------------------------------------------------------------
	AST_HOLD: assert property (GRANT_VALID && !GRANT_TAKE |=> GRANT_VALID && $stable(GRANT_QUEUE))
		else $error("offer changed before it was taken");
	AST_RELEASE: assert property (GRANT_VALID && GRANT_TAKE |=> !GRANT_VALID)
		else $error("offer stayed after take");
	AST_OFFER: assert property (!GRANT_VALID && QUEUE_READY != 8'h00 |=> GRANT_VALID && rdy_d[GRANT_QUEUE])
		else $error("no offer or offer of an empty queue");
	AST_IDLE: assert property (!GRANT_VALID && QUEUE_READY == 8'h00 |=> !GRANT_VALID)
		else $error("offer with no queue ready");
	AST_COS7: assert property (!GRANT_VALID && QUEUE_READY[7] |=> GRANT_QUEUE == 3'h7)
		else $error("queue seven not served first");
	AST_RO_WRITE: assert property (PSEL && PENABLE && PWRITE && PADDR inside {`A_STATUS, `A_PRIO_DEF, `A_WFQ_BASE} |-> PSLVERR)
		else $error("write to fixed register not refused");
endmodule // egress_qos_monitor

bind egress_qos_marker_scheduler egress_qos_monitor u_egress_qos_monitor (.*);

// file: verif/egress_qos_partner.sv
// partner: fabric queues holding frames, and the port taking offers
// assumes the bench loads pend while idle
`timescale 1ns/10ps
module egress_qos_partner
(
	input wire clk,
	input wire rst_b,
	input wire grant_valid,
	input wire [2:0] grant_queue,
	input wire slow,
	output logic [7:0] queue_ready,
	output logic grant_take,
	output logic tx_done,
	output logic [2:0] tx_queue,
	output logic tx_yellow,
	output logic [13:0] tx_bytes
);
	// ---------------------------------------------------------------
	// queue state
	// ---------------------------------------------------------------
	int pend [8] = '{default: 0}; // frames waiting per queue
	int wait_c = 0; // stall before the next take
	logic [2:0] log_q [$]; // granted queues, oldest first
	// a queue asks while it still holds a frame
	always_comb
		for (int q = 0; q < 8; q++)
			queue_ready[q] = pend[q] > 0;
	// take offers, stalling when slow, and report each frame sent
	always @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			grant_take <= 1'b0;
			tx_done <= 1'b0;
			tx_queue <= 3'h0;
			tx_yellow <= 1'b0;
			tx_bytes <= 14'h0000;
		end
		else
		begin
			tx_done <= 1'b0;
			if (grant_valid && grant_take)
			begin
				// nba, so ready never races the edge
				grant_take <= 1'b0;
				log_q.push_back(grant_queue);
				pend[grant_queue] <= pend[grant_queue] - 1;
				tx_done <= 1'b1;
				tx_queue <= grant_queue;
				tx_yellow <= grant_queue[0]; // odd queues carry yellow
				tx_bytes <= 14'h0040 + grant_queue;
			end
			else if (grant_valid && wait_c > 0)
				wait_c--;
			else if (grant_valid)
			begin
				grant_take <= 1'b1;
				wait_c = slow ? $urandom_range(3) : 0;
			end
		end
endmodule // egress_qos_partner

// file: verif/tb_egress_qos_marker_scheduler.sv
// testbench: directed and random checks of the egress qos block
// assumes the partner model and the bound monitor compile with it
`timescale 1ns/10ps
`include "egress_qos_consts.vh"
module tb_egress_qos_marker_scheduler;
	// ---------------------------------------------------------------
	// signals and mirrors
	// ---------------------------------------------------------------
	logic CLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, slow = 0;
	logic [7:0] PADDR = 0;
	logic [31:0] PWDATA = 0, r;
	wire [31:0] PRDATA;
	wire PREADY, PSLVERR, GRANT_VALID, GRANT_TAKE, TX_DONE, TX_YELLOW;
	wire [2:0] GRANT_QUEUE, TX_QUEUE, OUT_PCP;
	wire [7:0] QUEUE_READY;
	wire [13:0] TX_BYTES;
	wire OUT_VALID, OUT_DEI, OUT_IS_STAG, OUT_IS_CTAG, OUT_DROP;
	logic DROP_EV = 0, DROP_YELLOW = 0, FRM_VALID = 0, FRM_YELLOW = 0, e;
	logic FRM_MARK_EN = 0, FRM_ADD_TAG = 0, spres = 0, cpres = 0;
	logic [2:0] DROP_QUEUE = 0, FRM_COS = 0;
	logic [13:0] DROP_BYTES = 0, FRM_LEN = 0, mru;
	logic [15:0] FRM_ETYPE = 0;
	logic [15:0] ety [5] = '{16'h8100, 16'h88A8, 16'h9100, 16'h9200, 16'h0800};
	logic [2:0] ord [8] = '{3'h7, 3'h5, 3'h6, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
	logic [11:0] mk [8]; // mirror of the mark table
	logic [1:0] dmap = 2'h2, sety = 2'h1;
	int num_errors = 0, n_checks = 0, k;
	always #12.5 CLK = ~CLK;
	egress_qos_marker_scheduler #(.RATE_WIN_CYC(100))
		u_egress_qos_marker_scheduler (.*);
	egress_qos_partner u_egress_qos_partner (.clk(CLK), .rst_b(RST_B),
		.grant_valid(GRANT_VALID), .grant_queue(GRANT_QUEUE), .slow(slow),
		.queue_ready(QUEUE_READY), .grant_take(GRANT_TAKE), .tx_done(TX_DONE),
		.tx_queue(TX_QUEUE), .tx_yellow(TX_YELLOW), .tx_bytes(TX_BYTES));
	// ---------------------------------------------------------------
	// tasks and expectation
	// ---------------------------------------------------------------
	// verdict and end of run
	task results;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, g, x);
		end
	endtask
	// one apb transfer, held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge CLK);
		PSEL <= 1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1;
		n = 0;
		do
		begin
			@(posedge CLK);
			n++;
		end
		while (PREADY !== 1'b1 && n < 50);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
		if (n >= 50)
		begin
			num_errors++;
			results;
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(0, a, 32'h0);
		chk(r, x);
	endtask
	// counter pair: select, low word latches high, then high word
	task cnt(input logic [7:0] s, input logic [31:0] x);
		apb(1, `A_CNT_SEL, {24'h0, s});
		rd(`A_CNT_LO, x);
		rd(`A_CNT_HI, 32'h0);
	endtask
	// bounded wait for n grants taken by the partner
	task wait_log(input int n);
		k = 0;
		while (u_egress_qos_partner.log_q.size() < n && k < 2000)
		begin
			@(posedge CLK);
			k++;
		end
		if (k >= 2000)
		begin
			num_errors++;
			results;
		end
	endtask
	// expected {pcp, dei, s tag, c tag, drop} for one header
	function logic [6:0] mexp(logic [15:0] t, logic [2:0] cs,
		logic y, logic m, logic ad, logic [13:0] ln);
		logic s, c;
		logic [2:0] p;
		logic d;
		s = t == ety[sety];
		c = !s && t == 16'h8100;
		if ((s && spres) || (c && cpres))
		begin
			p = ad ? 3'h0 : cs;
			d = ad ? 1'b0 : y;
		end
		else
		begin
			y = y && m; // marking off uses green entries
			p = (s || ad) ? (y ? mk[cs][11:9] : mk[cs][8:6])
				: (y ? mk[cs][5:3] : mk[cs][2:0]);
			d = dmap[y];
		end
		return {p, d, s, c, ln > mru};
	endfunction
	// one random header, result checked the cycle after
	task frame(input int i);
		logic [15:0] t;
		logic [2:0] cs;
		logic y, m, ad;
		logic [13:0] ln;
		t = ety[$urandom_range(4)];
		cs = 3'($urandom);
		{y, m, ad} = 3'($urandom);
		ln = (i % 4 == 0) ? 14'($urandom_range(64)) : 14'($urandom);
		@(posedge CLK);
		FRM_VALID <= 1;
		FRM_ETYPE <= t;
		FRM_COS <= cs;
		{FRM_YELLOW, FRM_MARK_EN, FRM_ADD_TAG} <= {y, m, ad};
		FRM_LEN <= ln;
		@(posedge CLK);
		FRM_VALID <= 0;
		#1;
		chk({OUT_PCP, OUT_DEI, OUT_IS_STAG, OUT_IS_CTAG, OUT_DROP}, mexp(t, cs, y, m, ad, ln));
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h41F43B01));
		repeat (16) @(posedge CLK);
		RST_B <= 1;
		rd(`A_CTRL, 32'h00000419);
		rd(`A_MRU, 32'h0000258C);
		rd(`A_DEI_MAP, 32'h00000002);
		for (int c = 0; c < 8; c++)
		begin
			mk[c] = {4{c[2:0]}};
			rd(8'(`A_MARK_BASE + 4 * c), {20'h0, mk[c]});
		end
		// fixed registers and a hole refuse writes
		apb(1, `A_PRIO_DEF, 32'h0);
		chk(32'(e), 1);
		apb(1, `A_WFQ_BASE, 32'h0);
		chk(32'(e), 1);
		apb(1, 8'hF0, 32'h0);
		chk(32'(e), 1);
		rd(`A_PRIO_DEF, 32'h43322221);
		rd(`A_WFQ_BASE, 32'h11111111);
		apb(1, `A_MRU, 32'h0000000A);
		rd(`A_MRU, 32'h00000040);
		apb(1, `A_MRU, 32'h00003FFF);
		rd(`A_MRU, 32'h0000258C);
		// default profile, one frame each, stalling port
		slow <= 1;
		for (int q = 0; q < 8; q++)
			u_egress_qos_partner.pend[q] <= 1;
		wait_log(8);
		for (int i = 0; i < 8; i++)
			chk(u_egress_qos_partner.log_q[i], ord[i]);
		// two drop events back to back on queue three
		@(posedge CLK);
		DROP_EV <= 1;
		DROP_QUEUE <= 3'h3;
		DROP_BYTES <= 14'h0064;
		repeat (2) @(posedge CLK);
		DROP_EV <= 0;
		cnt(8'h0D, 32'h1);
		cnt(8'h2D, 32'h45);
		cnt(8'h04, 32'h1);
		cnt(8'h05, 32'h0);
		cnt(8'h13, 32'h2);
		cnt(8'h33, 32'hC8);
		// user profiles: cos0 level 4, cos7 level 1, weights 3:1
		apb(1, `A_PRIO_BASE, 32'h12222224);
		apb(1, `A_WFQ_BASE + 8'h04, 32'h11111131);
		apb(1, `A_CTRL, 32'h00000421);
		rd(`A_PRIO_BASE, 32'h12222224);
		u_egress_qos_partner.log_q.delete();
		slow <= 0;
		u_egress_qos_partner.pend <= '{1, 8, 8, 0, 0, 0, 0, 1};
		wait_log(18);
		chk(u_egress_qos_partner.log_q[0], 7);
		chk(u_egress_qos_partner.log_q[1], 0);
		k = 0;
		for (int i = 2; i < 10; i++)
			k += u_egress_qos_partner.log_q[i] == 3'h1;
		chk(k, 6);
		// marker under random settings
		for (int n = 0; n < 8; n++)
		begin
			{spres, cpres, sety, dmap} = 6'($urandom);
			mru = 14'($urandom_range(9612, 64));
			k = $urandom_range(7);
			mk[k] = 12'($urandom);
			apb(1, `A_CTRL, {20'h0, sety, cpres, spres, 8'h19});
			apb(1, `A_DEI_MAP, {30'h0, dmap});
			apb(1, `A_MRU, {18'h0, mru});
			apb(1, 8'(`A_MARK_BASE + 4 * k), {20'h0, mk[k]});
			for (int i = 0; i < 12; i++)
				frame(i);
		end
		results;
	end
endmodule // tb_egress_qos_marker_scheduler
